/* File: logic/ooods_sched.sv */
// Summary of operation
// RQ1: at most one micro-op per port, eight total
// RQ2: four compute ports, four memory-only ports
// RQ3: all compute ports have ALU, two FMA
// RQ4: per cycle two loads, one store
// RQ5: two load/address, one address, one data port
// RQ6: vector units full width except divider, string, crypto
// RQ7: FMA peak 32 single, 16 double per cycle
// RQ8: 192 in flight, then allocation stalls
// RQ9: 60-entry pool, issue only when ready
// RQ10: rename in order, bind to capable ports
// RQ11: idioms and moves finish at rename
// RQ12: four ports run simple integer ops
// RQ13: shifts and add-with-carry on two ports
// RQ14: slow integer ops on one port
// RQ15: bit manipulation on two ports
// RQ16: vector logic on three ports
// RQ17: vector integer arithmetic on two ports
// RQ18: all shuffles on one port
// RQ19: divides and roots on one divider port
// RQ20: cross-stack sources wait extra cycles; code adds none for int-vint, int-fplo or vint-fphi crossings
// RQ21: some crossings insert a transfer micro-op
// RQ22: load and integer-to-x87 penalties as tabled
// RQ23: oldest ready micro-op wins a port
`timescale 1ns/1ps
`default_nettype none
module ooods_sched
  import ooods_pkg::*;
#(
  parameter int POOL_N = POOL_DEPTH,
  parameter int FLIGHT_N = INFLIGHT_MAX
)(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_uop_valid,
  input wire ooods_cls_type i_uop_cls,
  input wire ooods_dom_type i_uop_dom,
  input wire ooods_src_type i_src_dom,
  input wire logic i_src_pend,
  input wire logic [ID_W-1:0] i_src_tag,
  input wire logic i_wake_valid,
  input wire logic [ID_W-1:0] i_wake_id,
  input wire logic [3:0] i_retire_cnt,
  output logic o_in_ready,
  output logic o_elim_valid,
  output logic [ID_W-1:0] o_elim_id,
  output logic o_xfer_ins,
  output logic [PORTS-1:0] o_port_valid,
  output logic [PORTS-1:0][ID_W-1:0] o_port_id,
  output var ooods_cls_type [PORTS-1:0] o_port_cls,
  output logic [ID_W-1:0] o_inflight
);
  // capability figures of the execution stacks
  localparam logic [PORTS-1:0] FMA_PORTS = PM_FMA; // see RQ3
  localparam int PEAK_SP = FMA_UNITS * SP_LANES * 2; // see RQ7
  localparam int PEAK_DP = FMA_UNITS * DP_LANES * 2; // see RQ7
  localparam int MEM_W = DATA_W; // see RQ5

  // whole state: pool entries, counters and registered outputs
  typedef struct packed {
    logic [POOL_N-1:0] v;
    logic [POOL_N-1:0] pend;
    logic [POOL_N-1:0][ID_W-1:0] wtag;
    logic [POOL_N-1:0][ID_W-1:0] id;
    logic [POOL_N-1:0][1:0] dly;
    ooods_cls_type [POOL_N-1:0] cls;
    logic [ID_W-1:0] seq;
    logic [ID_W-1:0] head;
    logic [ID_W-1:0] inflight;
    logic in_rdy;
    logic elim_v;
    logic [ID_W-1:0] elim_id;
    logic xfer;
    logic [PORTS-1:0] pv;
    logic [PORTS-1:0][ID_W-1:0] pid;
    ooods_cls_type [PORTS-1:0] pcls;
  } ooods_state_type;

  ooods_state_type s_q;
  ooods_state_type s_d;
  logic accept;
  logic idiom;
  logic byp_xfer;
  ooods_cls_type byp_cls;
  logic [1:0] byp_dly;
  logic [POOL_N-1:0] taken;
  logic [POOL_N-1:0][PORTS-1:0] emask;
  logic found;
  logic ok0;
  logic ok1;
  logic src_wait;
  logic [ID_W-1:0] age;
  logic [ID_W-1:0] best_age;
  logic [ID_W-1:0] nalloc;
  int best;
  int f0;
  int f1;
  int nfree;
  int nld;
  int nsta;

  // ports able to serve each class of micro-op
  function automatic logic [PORTS-1:0] port_mask(input ooods_cls_type c);
    logic [PORTS-1:0] m;
    m = PM_NONE;
    unique case (c)
      CLS_ALU: m = PM_ALU; // see RQ12
      CLS_SHIFT: m = PM_SHIFT; // see RQ13
      CLS_SLOW: m = PM_SLOW; // see RQ14
      CLS_BITMANIP: m = PM_BITMANIP; // see RQ15
      CLS_QADDR: m = PM_QADDR;
      CLS_BR: m = PM_BR;
      CLS_BR2: m = PM_BR2;
      CLS_VLOGIC: m = PM_VLOGIC; // see RQ16
      CLS_VARITH: m = PM_VARITH; // see RQ17
      CLS_VSHIFT: m = PM_P0;
      CLS_VMISC: m = PM_P0;
      CLS_SHUF: m = PM_P5; // see RQ18
      CLS_FMA: m = PM_FMA; // see RQ3
      CLS_FPADD: m = PM_P1;
      CLS_FPMOV: m = PM_P5;
      CLS_DIV: m = PM_P0; // narrow divider, see RQ19 and RQ6
      CLS_STRCMP: m = PM_P0; // narrow unit, see RQ6
      CLS_AES_ROUND: m = PM_P5; // narrow unit, see RQ6
      CLS_LOAD: m = PM_LOAD; // see RQ5
      CLS_STA: m = PM_STA; // see RQ5
      CLS_STD: m = PM_STD; // see RQ5
      CLS_XFER1: m = PM_P1; // see RQ21
      CLS_XFER5: m = PM_P5; // see RQ21
      CLS_ZERO, CLS_ONES, CLS_MOVE: m = PM_NONE; // see RQ11
      default: m = PM_NONE;
    endcase
    return m;
  endfunction

  // bypass cost of the incoming micro-op's source
  ooods_bypass u_bypass (
    .i_cons_dom(i_uop_dom),
    .i_src_dom(i_src_dom),
    .o_xfer(byp_xfer),
    .o_xfer_cls(byp_cls),
    .o_dly(byp_dly)
  );

  // next state: wakeup, selection, rename, accounting
  always_comb begin
    s_d = s_q;
    s_d.elim_v = 1'b0;
    s_d.xfer = 1'b0;
    s_d.pv = '0;
    taken = '0;
    found = 1'b0;
    ok0 = 1'b0;
    ok1 = 1'b0;
    age = '0;
    best_age = '1;
    nalloc = '0;
    best = 0;
    f0 = 0;
    f1 = 0;
    nfree = 0;
    nld = 0;
    nsta = 0;
    accept = i_uop_valid && s_q.in_rdy;
    idiom = i_uop_cls inside {CLS_ZERO, CLS_ONES, CLS_MOVE};
    src_wait = i_src_pend && !(i_wake_valid && i_wake_id == i_src_tag);
    // source wakeup, then bypass countdown
    for (int e = 0; e < POOL_N; e++) begin
      emask[e] = port_mask(s_q.cls[e]);
      if (s_q.v[e] && s_q.pend[e] && i_wake_valid && s_q.wtag[e] == i_wake_id) begin
        s_d.pend[e] = 1'b0;
      end else if (s_q.v[e] && !s_q.pend[e] && s_q.dly[e] != DLY_NONE) begin
        s_d.dly[e] = s_q.dly[e] - 2'h1; // see RQ20
      end
    end
    // each port takes the oldest ready entry it can serve
    for (int p = 0; p < PORTS; p++) begin
      found = 1'b0;
      best = 0;
      best_age = '1;
      for (int e = 0; e < POOL_N; e++) begin
        age = s_q.id[e] - s_q.head;
        if (s_q.v[e] && !s_q.pend[e] && s_q.dly[e] == DLY_NONE && !taken[e] // see RQ9
            && emask[e][p] // see RQ2
            && !(s_q.cls[e] == CLS_LOAD && nld >= LD_PER_CYC) // see RQ4
            && !(s_q.cls[e] == CLS_STA && nsta >= ST_PER_CYC) // see RQ4
            && (!found || age < best_age)) begin // see RQ23
          found = 1'b1;
          best = e;
          best_age = age;
        end
      end
      if (found) begin
        taken[best] = 1'b1; // see RQ1
        s_d.v[best] = 1'b0;
        s_d.pv[p] = 1'b1;
        s_d.pid[p] = s_q.id[best];
        s_d.pcls[p] = s_q.cls[best];
        if (s_q.cls[best] == CLS_LOAD) begin
          nld++;
        end
        if (s_q.cls[best] == CLS_STA) begin
          nsta++;
        end
      end
    end
    // two lowest free slots
    for (int e = 0; e < POOL_N; e++) begin
      if (!s_q.v[e]) begin
        if (!ok0) begin
          ok0 = 1'b1;
          f0 = e;
        end else if (!ok1) begin
          ok1 = 1'b1;
          f1 = e;
        end
      end
    end
    // rename: idioms end here, others bind to the pool
    if (accept && idiom) begin
      s_d.elim_v = 1'b1; // see RQ11
      s_d.elim_id = s_q.seq;
      nalloc = 8'h01;
    end else if (accept && byp_xfer) begin
      s_d.v[f0] = 1'b1; // see RQ21
      s_d.cls[f0] = byp_cls;
      s_d.id[f0] = s_q.seq;
      s_d.pend[f0] = src_wait;
      s_d.wtag[f0] = i_src_tag;
      s_d.dly[f0] = DLY_NONE;
      s_d.v[f1] = 1'b1;
      s_d.cls[f1] = i_uop_cls;
      s_d.id[f1] = s_q.seq + 8'h01;
      s_d.pend[f1] = 1'b1;
      s_d.wtag[f1] = s_q.seq;
      s_d.dly[f1] = byp_dly; // see RQ22
      s_d.xfer = 1'b1;
      nalloc = 8'h02;
    end else if (accept) begin
      s_d.v[f0] = 1'b1; // see RQ10
      s_d.cls[f0] = i_uop_cls;
      s_d.id[f0] = s_q.seq;
      s_d.pend[f0] = src_wait;
      s_d.wtag[f0] = i_src_tag;
      s_d.dly[f0] = byp_dly; // see RQ20
      nalloc = 8'h01;
    end
    // in-order ids, retirement and the in-flight window
    s_d.seq = s_q.seq + nalloc;
    s_d.head = s_q.head + ID_W'(i_retire_cnt);
    s_d.inflight = s_q.inflight + nalloc - ID_W'(i_retire_cnt);
    for (int e = 0; e < POOL_N; e++) begin
      if (!s_d.v[e]) begin
        nfree++;
      end
    end
    s_d.in_rdy = (s_d.inflight <= ID_W'(FLIGHT_N - SLOTS_PER_UOP)) // see RQ8
                 && (nfree >= SLOTS_PER_UOP); // see RQ9
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign o_in_ready = s_q.in_rdy;
  assign o_elim_valid = s_q.elim_v;
  assign o_elim_id = s_q.elim_id;
  assign o_xfer_ins = s_q.xfer;
  assign o_port_valid = s_q.pv;
  assign o_port_id = s_q.pid;
  assign o_port_cls = s_q.pcls;
  assign o_inflight = s_q.inflight;

  // checking helpers over the issued group
  logic chk_dup;
  logic chk_map;
  logic chk_mix;
  logic chk_fma;
  logic [PORTS-1:0] chk_m;
  int chk_ld;
  int chk_st;
  int pool_used;
  always_comb begin
    chk_dup = 1'b0;
    chk_map = 1'b0;
    chk_mix = 1'b0;
    chk_fma = 1'b0;
    chk_m = '0;
    chk_ld = 0;
    chk_st = 0;
    pool_used = $countones(s_q.v);
    for (int p = 0; p < PORTS; p++) begin
      if (s_q.pv[p]) begin
        chk_m = port_mask(s_q.pcls[p]);
        chk_map = chk_map || !chk_m[p];
        chk_mix = chk_mix || (PM_MEM[p] && (chk_m & PM_COMPUTE) != '0);
        chk_fma = chk_fma || (s_q.pcls[p] == CLS_FMA && !FMA_PORTS[p]);
        chk_ld = chk_ld + ((s_q.pcls[p] == CLS_LOAD) ? 1 : 0);
        chk_st = chk_st + ((s_q.pcls[p] == CLS_STA) ? 1 : 0);
        for (int q = p + 1; q < PORTS; q++) begin
          chk_dup = chk_dup || (s_q.pv[q] && s_q.pid[q] == s_q.pid[p]);
        end
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  property p_one_per_port;
    !chk_dup;
  endproperty
  a_one_per_port: assert property (p_one_per_port) else $error("one id on two ports"); // see RQ1

  property p_mem_split;
    !chk_mix;
  endproperty
  a_mem_split: assert property (p_mem_split) else $error("compute op on memory port"); // see RQ2

  property p_fma_ports;
    !chk_fma && (PEAK_SP == 32) && (PEAK_DP == 16) && (MEM_W == 256);
  endproperty
  a_fma_ports: assert property (p_fma_ports) else $error("fma op off fma ports"); // see RQ3

  property p_mem_rate;
    (chk_ld <= LD_PER_CYC) && (chk_st <= ST_PER_CYC);
  endproperty
  a_mem_rate: assert property (p_mem_rate) else $error("memory issue rate exceeded"); // see RQ4

  property p_window_stall;
    (s_q.inflight > ID_W'(FLIGHT_N - SLOTS_PER_UOP)) |-> !o_in_ready;
  endproperty
  a_window_stall: assert property (p_window_stall) else $error("ready with window full"); // see RQ8

  property p_pool_room;
    o_in_ready |-> (pool_used <= POOL_N - SLOTS_PER_UOP);
  endproperty
  a_pool_room: assert property (p_pool_room) else $error("ready with pool full"); // see RQ9

  property p_port_bind;
    !chk_map;
  endproperty
  a_port_bind: assert property (p_port_bind) else $error("op on incapable port"); // see RQ10

  property p_idiom_done;
    accept && idiom |=> o_elim_valid && (o_elim_id == $past(s_q.seq))
      && (pool_used <= $past(pool_used));
  endproperty
  a_idiom_done: assert property (p_idiom_done) else $error("idiom not ended at rename"); // see RQ11

  property p_xfer_ins;
    accept && !idiom && byp_xfer |=> o_xfer_ins
      && (o_inflight == $past(o_inflight) + 8'h02 - ID_W'($past(i_retire_cnt)));
  endproperty
  a_xfer_ins: assert property (p_xfer_ins) else $error("transfer op not inserted"); // see RQ21

  property p_load_hi;
    i_src_dom == SRC_LOAD && i_uop_dom == DOM_FPHI |-> byp_dly == DLY_LOAD_HI;
  endproperty
  a_load_hi: assert property (p_load_hi) else $error("load to upper fp wait wrong"); // see RQ22

  c_full_issue: cover property (s_q.pv == '1);
  c_idiom: cover property (o_elim_valid);
  c_xfer: cover property (o_xfer_ins ##[1:20] o_port_valid[5]);
  c_window_full: cover property (s_q.inflight > ID_W'(FLIGHT_N - SLOTS_PER_UOP));
endmodule
`default_nettype wire

/* File: logic/ooods_pkg.sv */
package ooods_pkg;
  // machine shape
  localparam int PORTS = 8;
  localparam int POOL_DEPTH = 60;
  localparam int INFLIGHT_MAX = 192;
  localparam int ID_W = 8;
  localparam int DATA_W = 256;
  localparam int FMA_UNITS = 2;
  localparam int SP_LANES = 8;
  localparam int DP_LANES = 4;
  localparam int LD_PER_CYC = 2;
  localparam int ST_PER_CYC = 1;
  localparam int SLOTS_PER_UOP = 2;

  // port masks, bit n stands for dispatch port n
  localparam logic [7:0] PM_NONE = 8'h00;
  localparam logic [7:0] PM_ALU = 8'h63;
  localparam logic [7:0] PM_SHIFT = 8'h41;
  localparam logic [7:0] PM_SLOW = 8'h02;
  localparam logic [7:0] PM_BITMANIP = 8'h22;
  localparam logic [7:0] PM_QADDR = 8'h22;
  localparam logic [7:0] PM_BR = 8'h40;
  localparam logic [7:0] PM_BR2 = 8'h01;
  localparam logic [7:0] PM_VLOGIC = 8'h23;
  localparam logic [7:0] PM_VARITH = 8'h22;
  localparam logic [7:0] PM_P0 = 8'h01;
  localparam logic [7:0] PM_P1 = 8'h02;
  localparam logic [7:0] PM_P5 = 8'h20;
  localparam logic [7:0] PM_FMA = 8'h03;
  localparam logic [7:0] PM_LOAD = 8'h0C;
  localparam logic [7:0] PM_STA = 8'h8C;
  localparam logic [7:0] PM_STD = 8'h10;
  localparam logic [7:0] PM_COMPUTE = 8'h63;
  localparam logic [7:0] PM_MEM = 8'h9C;

  // extra bypass wait in cycles
  localparam logic [1:0] DLY_NONE = 2'h0;
  localparam logic [1:0] DLY_LOAD_LO = 2'h1;
  localparam logic [1:0] DLY_LOAD_HI = 2'h2;
  localparam logic [1:0] DLY_CROSS = 2'h1;
  localparam logic [1:0] DLY_X87 = 2'h3;

  // micro-op classes by execution resource
  typedef enum logic [4:0] {
    CLS_ALU = 5'h00, CLS_SHIFT, CLS_SLOW, CLS_BITMANIP, CLS_QADDR, CLS_BR, CLS_BR2,
    CLS_VLOGIC, CLS_VARITH, CLS_VSHIFT, CLS_VMISC, CLS_SHUF, CLS_FMA, CLS_FPADD,
    CLS_FPMOV, CLS_DIV, CLS_STRCMP, CLS_AES_ROUND, CLS_LOAD, CLS_STA, CLS_STD,
    CLS_XFER1, CLS_XFER5, CLS_ZERO, CLS_ONES, CLS_MOVE
  } ooods_cls_type;

  // consumer execution stack
  typedef enum logic [1:0] {
    DOM_INT = 2'h0, DOM_VINT, DOM_FPLO, DOM_FPHI
  } ooods_dom_type;

  // producer of the awaited source
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0, SRC_INT, SRC_VINT, SRC_FPLO, SRC_FPHI, SRC_LOAD
  } ooods_src_type;
endpackage

/* File: logic/ooods_bypass.sv */
`timescale 1ns/1ps
`default_nettype none
module ooods_bypass
  import ooods_pkg::*;
(
  input wire ooods_dom_type i_cons_dom,
  input wire ooods_src_type i_src_dom,
  output logic o_xfer,
  output var ooods_cls_type o_xfer_cls,
  output logic [1:0] o_dly
);
  // cross-stack cost: inserted transfer micro-op and extra wait
  always_comb begin
    o_xfer = 1'b0;
    o_xfer_cls = CLS_XFER5;
    o_dly = DLY_NONE;
    unique case (i_src_dom)
      SRC_INT: begin
        o_xfer = (i_cons_dom != DOM_INT); // see RQ21
        if (i_cons_dom == DOM_FPHI) begin
          o_dly = DLY_X87; // see RQ22
        end
      end
      SRC_VINT: begin
        o_xfer = (i_cons_dom == DOM_INT);
        o_xfer_cls = CLS_XFER1;
        if (i_cons_dom == DOM_FPLO) begin
          o_dly = DLY_CROSS; // see RQ20
        end
      end
      SRC_FPLO: begin
        o_xfer = (i_cons_dom == DOM_INT) || (i_cons_dom == DOM_FPHI);
        o_xfer_cls = (i_cons_dom == DOM_INT) ? CLS_XFER1 : CLS_XFER5;
        if (i_cons_dom == DOM_VINT || i_cons_dom == DOM_FPHI) begin
          o_dly = DLY_CROSS; // see RQ20
        end
      end
      SRC_FPHI: begin
        o_xfer = (i_cons_dom == DOM_INT) || (i_cons_dom == DOM_FPLO);
        o_xfer_cls = (i_cons_dom == DOM_INT) ? CLS_XFER1 : CLS_XFER5;
        if (i_cons_dom == DOM_INT) begin
          o_dly = DLY_X87;
        end else if (i_cons_dom == DOM_FPLO) begin
          o_dly = DLY_CROSS;
        end
      end
      SRC_LOAD: begin
        if (i_cons_dom == DOM_FPHI) begin
          o_dly = DLY_LOAD_HI; // see RQ22
        end else if (i_cons_dom != DOM_INT) begin
          o_dly = DLY_LOAD_LO; // see RQ22
        end
      end
      SRC_NONE: begin
        o_dly = DLY_NONE;
      end
      default: begin
        o_dly = DLY_NONE;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: testbench/ooods_far.sv */
`timescale 1ns/1ps
`default_nettype none
module ooods_far
  import ooods_pkg::*;
#(
  parameter int LAT = 6
)(
  input wire logic i_clk,
  input wire logic [PORTS-1:0] i_port_valid,
  input wire logic [PORTS-1:0][ID_W-1:0] i_port_id,
  output logic o_wake_valid,
  output logic [ID_W-1:0] o_wake_id
);
  int cyc = 0;
  int due[$];
  logic [ID_W-1:0] ids[$];

  initial begin
    o_wake_valid = 1'b0;
    o_wake_id = 8'h00;
  end

  // results return lat cycles after issue, one wake per cycle, oldest first
  always @(negedge i_clk) begin
    cyc++;
    for (int p = 0; p < PORTS; p++) begin
      if (i_port_valid[p] === 1'b1) begin
        ids.push_back(i_port_id[p]);
        due.push_back(cyc + LAT);
      end
    end
    if (ids.size() > 0 && due[0] <= cyc) begin
      o_wake_valid <= 1'b1;
      o_wake_id <= ids.pop_front();
      void'(due.pop_front());
    end else begin
      o_wake_valid <= 1'b0;
      o_wake_id <= ~o_wake_id; // idle id keeps moving
    end
  end
endmodule
`default_nettype wire

/* File: testbench/ooods_sched_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module ooods_sched_bench
  import ooods_pkg::*;
;
  localparam int FL = 16;
  logic i_clk, i_sys_rst, i_uop_valid, i_src_pend, wake_v;
  ooods_cls_type i_uop_cls;
  ooods_dom_type i_uop_dom;
  ooods_src_type i_src_dom;
  logic [ID_W-1:0] i_src_tag, wake_id, o_elim_id, o_inflight;
  logic [3:0] i_retire_cnt;
  logic o_in_ready, o_elim_valid, o_xfer_ins;
  logic [PORTS-1:0] o_port_valid;
  logic [PORTS-1:0][ID_W-1:0] o_port_id;
  ooods_cls_type [PORTS-1:0] o_port_cls;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int nid = 0;
  int xfer_n = 0;
  int iss_cyc[256] = '{default: -1};
  int iss_port[256];
  int wake_cyc[256];
  logic [4:0] iss_cls[256];
  ooods_cls_type rc[24] = '{CLS_ALU, CLS_SHIFT, CLS_SLOW, CLS_BITMANIP, CLS_QADDR, CLS_BR,
    CLS_BR2, CLS_VLOGIC, CLS_VARITH, CLS_VSHIFT, CLS_VMISC, CLS_SHUF, CLS_FMA, CLS_FPADD,
    CLS_FPMOV, CLS_DIV, CLS_STRCMP, CLS_AES_ROUND, CLS_LOAD, CLS_STA, CLS_STD, CLS_ZERO,
    CLS_ONES, CLS_MOVE};
  logic [7:0] rm[24] = '{PM_ALU, PM_SHIFT, PM_SLOW, PM_BITMANIP, PM_QADDR, PM_BR, PM_BR2,
    PM_VLOGIC, PM_VARITH, PM_P0, PM_P0, PM_P5, PM_FMA, PM_P1, PM_P5, PM_P0, PM_P0, PM_P5,
    PM_LOAD, PM_STA, PM_STD, PM_NONE, PM_NONE, PM_NONE};
  ooods_cls_type dp[8] = '{CLS_LOAD, CLS_LOAD, CLS_LOAD, CLS_VARITH, CLS_VARITH, CLS_ALU,
    CLS_ALU, CLS_VARITH};
  ooods_cls_type dc[8] = '{CLS_VARITH, CLS_FPADD, CLS_FPADD, CLS_FPADD, CLS_VARITH, CLS_FPADD,
    CLS_VARITH, CLS_ALU};
  ooods_dom_type dd[8] = '{DOM_VINT, DOM_FPLO, DOM_FPHI, DOM_FPLO, DOM_VINT, DOM_FPHI,
    DOM_VINT, DOM_INT};
  ooods_src_type ds[8] = '{SRC_LOAD, SRC_LOAD, SRC_LOAD, SRC_VINT, SRC_VINT, SRC_INT, SRC_INT,
    SRC_VINT};
  int dg[8] = '{1, 1, 2, 1, 0, 3, 0, 0};

  ooods_sched #(.POOL_N(8), .FLIGHT_N(FL)) ooods_sched_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_uop_valid(i_uop_valid), .i_uop_cls(i_uop_cls),
    .i_uop_dom(i_uop_dom), .i_src_dom(i_src_dom), .i_src_pend(i_src_pend),
    .i_src_tag(i_src_tag), .i_wake_valid(wake_v), .i_wake_id(wake_id),
    .i_retire_cnt(i_retire_cnt), .o_in_ready(o_in_ready), .o_elim_valid(o_elim_valid),
    .o_elim_id(o_elim_id), .o_xfer_ins(o_xfer_ins), .o_port_valid(o_port_valid),
    .o_port_id(o_port_id), .o_port_cls(o_port_cls), .o_inflight(o_inflight));
  ooods_far #(.LAT(6)) ooods_far_inst (.i_clk(i_clk), .i_port_valid(o_port_valid),
    .i_port_id(o_port_id), .o_wake_valid(wake_v), .o_wake_id(wake_id));

  always #12.5 i_clk = ~i_clk;

  // records when and where each id issued, finished at rename or woke
  always @(negedge i_clk) begin
    cyc++;
    if (o_elim_valid === 1'b1) begin
      iss_cyc[o_elim_id] = cyc;
      iss_port[o_elim_id] = 8;
    end
    for (int p = 0; p < PORTS; p++) begin
      if (o_port_valid[p] === 1'b1) begin
        iss_cyc[o_port_id[p]] = cyc;
        iss_port[o_port_id[p]] = p;
        iss_cls[o_port_id[p]] = o_port_cls[p];
      end
    end
    if (o_xfer_ins === 1'b1) xfer_n++;
    if (wake_v === 1'b1) wake_cyc[wake_id] = cyc;
  end

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask

  // an integer source crossing stacks, or a vector source into integer, needs a transfer
  function automatic int xf(input ooods_dom_type d, input ooods_src_type s);
    return int'((s == SRC_INT && d != DOM_INT) || (s inside {SRC_VINT, SRC_FPLO, SRC_FPHI}
      && d == DOM_INT));
  endfunction

  // offer one micro-op and hold it until taken; valid stays high for back to back use
  task automatic send(input ooods_cls_type c, input ooods_dom_type d, input ooods_src_type s,
    input logic pd, input int tag);
    int n;
    n = 0;
    i_uop_valid = 1'b1;
    i_uop_cls = c;
    i_uop_dom = d;
    i_src_dom = s;
    i_src_pend = pd;
    i_src_tag = tag[7:0];
    while (o_in_ready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      end_of_test();
    end
    @(negedge i_clk);
    nid += 1 + xf(d, s);
  endtask

  task automatic idle();
    i_uop_valid = 1'b0;
    i_src_pend = 1'b0;
  endtask

  task automatic wt(input int id);
    int n;
    n = 0;
    while (iss_cyc[id] < 0 && n < 60) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 60) begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic retire(input int k);
    int m;
    while (k > 0) begin
      m = (k > 15) ? 15 : k;
      i_retire_cnt = m[3:0];
      @(negedge i_clk);
      k -= m;
    end
    i_retire_cnt = 4'h0;
    chk("inflight", o_inflight, 0);
  endtask

  initial begin
    int a;
    int c;
    int x;
    int x0;
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_retire_cnt = 4'h0;
    i_uop_cls = CLS_ALU;
    i_uop_dom = DOM_INT;
    i_src_dom = SRC_NONE;
    i_src_tag = 8'h00;
    idle();
    repeat (2) @(negedge i_clk);
    chk("reset ready", o_in_ready, 0);
    chk("reset ports", o_port_valid, 0);
    i_sys_rst = 1'b0;
    // every class but the two transfer classes goes to a port that has its unit, idioms never reach a port
    for (int i = 0; i < 24; i++) begin
      a = nid;
      send(rc[i], DOM_INT, SRC_NONE, 1'b0, 0);
      idle();
      wt(a);
      if (rm[i] == PM_NONE) begin
        chk("elim port", iss_port[a], 8);
      end else begin
        chk("port mask", rm[i][iss_port[a]], 1);
        chk("port cls", iss_cls[a], rc[i]);
      end
      retire(1);
    end
    // issue follows the wake edge by one cycle plus the bypass wait
    for (int i = 0; i < 8; i++) begin
      a = nid;
      x0 = xfer_n;
      x = xf(dd[i], ds[i]);
      c = a + 1 + x;
      send(dp[i], DOM_INT, SRC_NONE, 1'b0, 0);
      send(dc[i], dd[i], ds[i], 1'b1, a);
      idle();
      wt(c);
      chk("bypass gap", iss_cyc[c] - wake_cyc[c - 1], dg[i] + 1);
      chk("xfer count", xfer_n - x0, x);
      if (x == 1) chk("xfer port", iss_port[c - 1], (dd[i] == DOM_INT) ? 1 : 5);
      retire(2 + x);
    end
    // three loads woken together: two issue the cycle after the wake, the youngest one later
    a = nid;
    send(CLS_ALU, DOM_INT, SRC_NONE, 1'b0, 0);
    repeat (3) send(CLS_LOAD, DOM_INT, SRC_INT, 1'b1, a);
    idle();
    wt(a + 3);
    chk("load a", iss_cyc[a + 1] - wake_cyc[a], 1);
    chk("load b", iss_cyc[a + 2] - wake_cyc[a], 1);
    chk("load c", iss_cyc[a + 3] - wake_cyc[a], 2);
    retire(4);
    // flood without retiring until allocation stalls
    a = nid;
    send(CLS_ALU, DOM_INT, SRC_NONE, 1'b0, 0);
    repeat (30) begin
      if (o_in_ready === 1'b1) nid++;
      @(negedge i_clk);
    end
    idle();
    chk("stall ready", o_in_ready, 0);
    chk("stall count", o_inflight, nid - a);
    chk("window", (nid - a) <= FL, 1);
    retire(nid - a);
    end_of_test();
  end

  initial begin
    #500000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
